// ---- hw/arcd_rate_gen.sv ----
// rate generator: modulator strobe, conversion strobe, settling and output clipping
`default_nettype none
// Functional notes
// - all channels share one clock; filters start on the same modulator cycle
// - one output word per 64 modulator strobes in both modes
// - modulator divide is 8, 4, 40 or 8 by mode and divide select
// - conversion period is 512, 256, 2560 or 512 master clocks
// - output rate scales with master clock; ratios change only with the mode and divide select pins
// - outputs barely move before 30 periods, settled after 76
// - clip at 7fff for positive and 8000 for negative full scale
// - mode pin watched continuously; a change applies without reset
// - fixed latency from input to output word, independent of frequency
// - each result is a 16-bit two's complement word
// - ready stays high after a mode change until settled data exist
module arcd_rate_gen
   import arcd_pkg::*;
#(
   parameter int unsigned ACC_W = 24
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // pins
   input wire logic speed_mode,
   input wire logic clock_divide_select,
   // filter raw result, signed, wider than the output word
   input wire logic signed [ACC_W-1:0] filter_raw,
   // strobes
   output logic mod_strobe,
   output logic conv_strobe,
   output logic filter_start,
   // result
   output logic [RES_W-1:0] result_word,
   output logic result_ready_n,
   output logic settle_partial
);
   // last count of the decimation counter
   localparam logic [5:0] OSR_LAST = 6'(OSR - 1);

   // ======================================================
   // mode tracking
   logic mode_q, mode_d;
   logic div_sel_q, div_sel_d;
   logic mode_changed, sel_changed;
   logic restart;
   logic [5:0] div_ratio;

   // pins are compared with their registered copies on every edge
   assign mode_changed = (speed_mode != mode_q);
   assign sel_changed = (clock_divide_select != div_sel_q);

   // a pin change restarts the chain so the new ratio starts cleanly
   assign restart = mode_changed || sel_changed;

   always_comb begin
      mode_d = speed_mode;
      div_sel_d = clock_divide_select;
   end

   // the divider runs on the registered pins, never on a half-applied change
   always_comb begin
      unique case ({mode_q, div_sel_q})
         {MODE_HIGH_SPEED, 1'b1}: div_ratio = DIV_HS_SEL1;
         {MODE_HIGH_SPEED, 1'b0}: div_ratio = DIV_HS_SEL0;
         {MODE_LOW_POWER, 1'b1}: div_ratio = DIV_LP_SEL1;
         {MODE_LOW_POWER, 1'b0}: div_ratio = DIV_LP_SEL0;
      endcase
   end

   // registered pin copies, reset to high speed with select low
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_q <= MODE_HIGH_SPEED;
         div_sel_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         div_sel_q <= div_sel_d;
      end
   end

   // ======================================================
   // modulator strobe from the shared master-clock counter
   arcd_mod_divider u_div (
      .clk(clk),
      .rst_b(rst_b),
      .restart(restart),
      .div_ratio(div_ratio),
      .mod_strobe(mod_strobe)
   );

   // ======================================================
   // decimation counter: one conversion per OSR modulator strobes
   logic [5:0] osr_q, osr_d;
   logic conv_q, conv_d;
   logic start_q, start_d;
   logic conv_due;

   // the last strobe of a period closes the conversion
   assign conv_due = mod_strobe && (osr_q == OSR_LAST);

   // restart also clears the count, so a changed ratio starts a full period
   always_comb begin
      osr_d = osr_q;
      conv_d = 1'b0;
      start_d = 1'b0;
      if (restart) begin
         // a discarded period restarts every channel filter together
         osr_d = 6'h00;
         start_d = 1'b1;
      end else if (conv_due) begin
         osr_d = 6'h00;
         conv_d = 1'b1;
         start_d = 1'b1;
      end else if (mod_strobe) begin
         osr_d = osr_q + 6'h01;
      end
   end

   // strobes are registered so every channel sees them on the same edge
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         osr_q <= 6'h00;
         conv_q <= 1'b0;
         start_q <= 1'b0;
      end else begin
         osr_q <= osr_d;
         conv_q <= conv_d;
         start_q <= start_d;
      end
   end

   // ======================================================
   // settling span in conversion periods since the last restart
   logic [7:0] settle_q, settle_d;
   logic ready_n_q, ready_n_d;
   logic partial_q, partial_d;
   logic [7:0] settle_next;

   // saturate so a long run never wraps back to unsettled
   assign settle_next = (settle_q == SETTLE_FULL) ? settle_q : settle_q + 8'h01;

   // restart wins over a conversion in the same cycle: that period is void
   always_comb begin
      settle_d = settle_q;
      ready_n_d = ready_n_q;
      partial_d = partial_q;
      if (restart) begin
         settle_d = 8'h00;
         ready_n_d = 1'b1;
         partial_d = 1'b0;
      end else if (conv_due) begin
         settle_d = settle_next;
         if (settle_next >= SETTLE_LITTLE) begin
            partial_d = 1'b1;
         end
         ready_n_d = (settle_next < SETTLE_FULL);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         settle_q <= 8'h00;
         ready_n_q <= 1'b1;
         partial_q <= 1'b0;
      end else begin
         settle_q <= settle_d;
         ready_n_q <= ready_n_d;
         partial_q <= partial_d;
      end
   end

   // ======================================================
   // result word: the wide filter value clipped to the output range
   logic [RES_W-1:0] word_q, word_d;
   logic [RES_W-1:0] clip_word;
   logic signed [ACC_W-1:0] pos_lim, neg_lim;

   // limits sit on the wide value so an overrange never wraps
   assign pos_lim = ACC_W'(signed'({1'b0, CODE_POS_FS}));
   assign neg_lim = -ACC_W'(signed'({1'b0, CODE_NEG_FS}));

   // two's complement word, so the low bits already carry the sign
   always_comb begin
      if (filter_raw >= pos_lim) begin
         clip_word = CODE_POS_FS;
      end else if (filter_raw <= neg_lim) begin
         clip_word = CODE_NEG_FS;
      end else begin
         clip_word = filter_raw[RES_W-1:0];
      end
   end

   // the word holds between conversions and across a restart
   always_comb begin
      word_d = word_q;
      if (conv_due && !restart) begin
         word_d = clip_word;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         word_q <= '0;
      end else begin
         word_q <= word_d;
      end
   end

   // ======================================================
   // outputs, all straight from flip-flops
   assign conv_strobe = conv_q;
   assign filter_start = start_q;
   assign result_word = word_q;
   assign result_ready_n = ready_n_q;
   assign settle_partial = partial_q;
endmodule : arcd_rate_gen
`default_nettype wire

// ---- hw/arcd_pkg.sv ----
// package: constants for the converter rate and clock-divider block
`default_nettype none
package arcd_pkg;
   // oversampling ratio, modulator strobes per output word
   localparam int unsigned OSR = 64;
   // master clocks per modulator strobe
   localparam logic [5:0] DIV_HS_SEL1 = 6'h08;
   localparam logic [5:0] DIV_HS_SEL0 = 6'h04;
   localparam logic [5:0] DIV_LP_SEL1 = 6'h28;
   localparam logic [5:0] DIV_LP_SEL0 = 6'h08;
   // settling spans in conversion periods
   localparam logic [7:0] SETTLE_LITTLE = 8'h1e;
   localparam logic [7:0] SETTLE_FULL = 8'h4c;
   // result word
   localparam int unsigned RES_W = 16;
   localparam logic [15:0] CODE_POS_FS = 16'h7fff;
   localparam logic [15:0] CODE_NEG_FS = 16'h8000;
   // mode pin levels
   localparam logic MODE_HIGH_SPEED = 1'b0;
   localparam logic MODE_LOW_POWER = 1'b1;
endpackage : arcd_pkg
`default_nettype wire

// ---- hw/arcd_mod_divider.sv ----
// modulator strobe divider: one master-clock counter, strobe at terminal count
`default_nettype none
module arcd_mod_divider
   import arcd_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // control
   input wire logic restart,
   input wire logic [5:0] div_ratio,
   // strobe
   output logic mod_strobe
);
   logic [5:0] cnt_q, cnt_d;
   logic strobe_q, strobe_d;

   always_comb begin
      strobe_d = 1'b0;
      if (restart) begin
         cnt_d = 6'h00;
      end else if (cnt_q >= div_ratio - 6'h01) begin
         cnt_d = 6'h00;
         strobe_d = 1'b1;
      end else begin
         cnt_d = cnt_q + 6'h01;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= 6'h00;
         strobe_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         strobe_q <= strobe_d;
      end
   end

   assign mod_strobe = strobe_q;
endmodule : arcd_mod_divider
`default_nettype wire

// ---- verif/arcd_board.sv ----
// board side model: pin levels applied at the falling edge
`default_nettype none
module arcd_board (
   // clock and request
   input wire logic clk,
   input wire logic [1:0] want_pins,
   // pins
   output logic speed_mode,
   output logic clock_divide_select
);
   timeunit 1ns;
   timeprecision 1ps;
   always @(negedge clk) {speed_mode, clock_divide_select} <= want_pins;
endmodule : arcd_board
`default_nettype wire

// ---- verif/arcd_monitor.sv ----
// checker for the rate generator ports
`default_nettype none
module arcd_monitor
   import arcd_pkg::*;
#(parameter int unsigned ACC_W = 24) (
   // clock, reset, pins
   input wire logic clk,
   input wire logic rst_b,
   input wire logic speed_mode,
   input wire logic clock_divide_select,
   input wire logic signed [ACC_W-1:0] filter_raw,
   // outputs
   input wire logic mod_strobe,
   input wire logic conv_strobe,
   input wire logic filter_start,
   input wire logic [RES_W-1:0] result_word,
   input wire logic result_ready_n,
   input wire logic settle_partial
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] pin_q;
   logic [11:0] qt_q, mg_q, cg_q;
   logic [5:0] nd;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   assign nd = speed_mode ? (clock_divide_select ? DIV_LP_SEL1 : DIV_LP_SEL0)
      : (clock_divide_select ? DIV_HS_SEL1 : DIV_HS_SEL0);
   // qt_q counts clocks since the last pin change, saturating
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         {pin_q, qt_q, mg_q, cg_q} <= '0;
      end else begin
         pin_q <= {speed_mode, clock_divide_select};
         qt_q <= (pin_q != {speed_mode, clock_divide_select}) ? 12'h0 : qt_q + {11'h0, ~&qt_q};
         mg_q <= mod_strobe ? 12'h1 : mg_q + 12'h1;
         cg_q <= conv_strobe ? 12'h1 : cg_q + 12'h1;
      end
   end
   mod_gap_a: assert property (mod_strobe && qt_q > 12'h40 |-> mg_q == {6'h0, nd})
      else $error("mod gap");
   conv_gap_a: assert property (conv_strobe && &qt_q |-> cg_q == {nd, 6'h0})
      else $error("conv gap");
   conv_mod_a: assert property (conv_strobe |-> $past(mod_strobe))
      else $error("conv not after mod");
   conv_start_a: assert property (conv_strobe |-> filter_start)
      else $error("no filter start");
   clip_pos_a: assert property (conv_strobe && $past(filter_raw) > 32'sh7fff
      |-> result_word == CODE_POS_FS) else $error("pos clip");
   clip_neg_a: assert property (conv_strobe && $past(filter_raw) < -32'sh8000
      |-> result_word == CODE_NEG_FS) else $error("neg clip");
   word_hold_a: assert property (!conv_strobe |-> $stable(result_word))
      else $error("word moved");
   pin_restart_a: assert property ($changed({speed_mode, clock_divide_select}) |=> filter_start && result_ready_n)
      else $error("no restart");
   ready_settle_a: assert property (!result_ready_n |-> settle_partial)
      else $error("ready early");
   cover property (conv_strobe && speed_mode && clock_divide_select);
   cover property ($fell(result_ready_n));
   cover property (conv_strobe && result_word == CODE_NEG_FS);
endmodule : arcd_monitor
bind arcd_rate_gen arcd_monitor #(.ACC_W(ACC_W)) i_arcd_monitor (.*);
`default_nettype wire

// ---- verif/tb_top.sv ----
// self-checking bench for the rate generator
`default_nettype none
module tb_top;
   import arcd_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [1:0] want_pins = 2'h0;
   logic signed [23:0] filter_raw = '0;
   logic speed_mode, clock_divide_select, mod_strobe, conv_strobe, filter_start;
   logic result_ready_n, settle_partial;
   logic [15:0] result_word;
   int n_mismatch = 0;
   int n_compared = 0;
   int c, k;
   // divide per {mode, select}
   int ndiv_t [4] = '{4, 8, 8, 40};
   arcd_board i_arcd_board (
      .clk(clk),
      .want_pins(want_pins),
      .speed_mode(speed_mode),
      .clock_divide_select(clock_divide_select)
   );
   arcd_rate_gen i_arcd_rate_gen (
      .clk(clk),
      .rst_b(rst_b),
      .speed_mode(speed_mode),
      .clock_divide_select(clock_divide_select),
      .filter_raw(filter_raw),
      .mod_strobe(mod_strobe),
      .conv_strobe(conv_strobe),
      .filter_start(filter_start),
      .result_word(result_word),
      .result_ready_n(result_ready_n),
      .settle_partial(settle_partial)
   );
   initial forever #2 clk = ~clk;
   function automatic logic signed [23:0] rnd();
      case ($urandom % 4)
         0: return 24'sh007fff + 24'($urandom % 2);
         1: return -24'sh008000 - 24'($urandom % 2);
         2: return 24'($urandom);
         default: return 24'($signed(16'($urandom)));
      endcase
   endfunction : rnd
   function automatic logic [15:0] clip(input logic signed [23:0] v);
      if (v > 24'sh007fff) return CODE_POS_FS;
      if (v < -24'sh008000) return CODE_NEG_FS;
      return v[15:0];
   endfunction : clip
   task automatic give_verdict();
      if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : give_verdict
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   task automatic next_conv(output int clks, output int mods);
      clks = 0;
      mods = 0;
      do begin
         @(negedge clk);
         clks++;
         mods += int'(mod_strobe);
         if (clks > 3000) begin
            n_mismatch++;
            give_verdict();
         end
      end while (conv_strobe !== 1'b1);
      check(result_word, clip(filter_raw));
   endtask : next_conv
   always @(negedge clk) filter_raw <= rnd();
   initial begin
      void'($urandom(52232));
      repeat (8) @(negedge clk);
      rst_b <= 1'b1;
      for (int m = 0; m < 4; m++) begin
         want_pins <= 2'(m);
         repeat (3) next_conv(c, k);
         check(16'(c), 16'(64 * ndiv_t[m]));
         check(16'(k), 16'h0040);
      end
      want_pins <= 2'h0;
      for (int i = 1; i <= 80; i++) begin
         next_conv(c, k);
         @(negedge clk);
         check(16'(settle_partial), 16'(i >= 30));
         check(16'(result_ready_n), 16'(i < 76));
      end
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
